/* logic/hall_pkg.sv */
// Purpose: Shared constants and types for the Hall commutation block.
// Assumes: Phase A is bit 0 of a bridge mask, phase C is bit 2.
// Notes: Hall codes are written {A,B,C} with A as the top bit.
`default_nettype none
package hall_pkg;
	// Drive schemes in strap level order, lowest level first.
	typedef enum logic [2:0] {
		SCHEME_ASYNC_ANALOG,
		SCHEME_ASYNC_DIGITAL,
		SCHEME_SYNC_ANALOG,
		SCHEME_SYNC_DIGITAL,
		SCHEME_RECT_ANALOG,
		SCHEME_RECT_DIGITAL,
		SCHEME_UNASSIGNED
	} scheme_e;

	// Gate commands for the three half-bridges.
	typedef struct packed {
		logic [2:0] hs;
		logic [2:0] ls;
	} bridge_s;

	// Special Hall codes.
	localparam logic [2:0] CODE_STOP  = 3'h0;
	localparam logic [2:0] CODE_ALIGN = 3'h7;
	localparam int         STEPS      = 6;
	localparam logic [2:0] STEP_LAST  = 3'h5;
	localparam logic [2:0] STEP_FIRST = 3'h0;
	localparam logic [2:0] STEP_INC   = 3'h1;

	// Forward Hall code, modulated phase and on low side of each step.
	localparam logic [2:0] STEP_CODE [STEPS] = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};
	localparam logic [2:0] STEP_HI   [STEPS] = '{3'h2, 3'h1, 3'h1, 3'h4, 3'h4, 3'h2};
	localparam logic [2:0] STEP_LO   [STEPS] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h1};
	localparam logic [2:0] ALIGN_HI  = 3'h1;
	localparam logic [2:0] ALIGN_LO  = 3'h6;

	// Nominal lead angle in degrees for each three-bit lead code.
	localparam logic [4:0] LEAD_DEG [8] = '{5'h00, 5'h04, 5'h07, 5'h0b,
		5'h0f, 5'h14, 5'h19, 5'h1e};
	// Lead code chosen by each of the seven strap levels.
	localparam logic [2:0] LEAD_STRAP_CODE [7] = '{3'h0, 3'h1, 3'h3, 3'h4,
		3'h5, 3'h6, 3'h7};
	localparam logic [2:0] STRAP_LVL_MAX = 3'h6;
	localparam logic [5:0] DEG_PER_STEP  = 6'h3c;
	localparam logic [4:0] DEG_ZERO      = 5'h00;

	// Register map, byte addresses on the APB.
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [31:0] CTRL_RESET  = 32'h0;
	localparam int CTRL_SRC_BIT    = 0;
	localparam int CTRL_SCHEME_LSB = 1;
	localparam int CTRL_LEAD_LSB   = 4;
	localparam int CTRL_SLEW_LSB   = 7;
	localparam int CTRL_SDO_OD_BIT = 9;
	localparam int ST_HALL_LSB     = 0;
	localparam int ST_SCHEME_LSB   = 3;
	localparam int ST_STEP_LSB     = 6;
	localparam int ST_BRAKE_BIT    = 9;
	localparam int ST_DIR_BIT      = 10;
	localparam int ST_STRAP_LSB    = 11;
endpackage
`default_nettype wire

/* logic/hall_channel.sv */
// Purpose: One Hall position channel: synchroniser and comparator.
// Assumes: Sensor levels arrive as unsigned samples of width W.
// Notes: Digital sensing looks at the positive input only.
`timescale 1ns/1ps
`default_nettype none
module hall_channel #(
	parameter int W = 8
) (
	// Clock and reset.
	input  wire logic         sys_clk_i,
	input  wire logic         srst_i,
	// Sensor pair and sensing mode.
	input  wire logic [W-1:0] pos_i,
	input  wire logic [W-1:0] neg_i,
	input  wire logic         analog_i,
	// Decoded position bit.
	output logic              bit_o
);
	logic [W-1:0] pos_s1_q;  // First synchroniser stage, positive input.
	logic [W-1:0] neg_s1_q;  // First synchroniser stage, negative input.
	logic [W-1:0] pos_s2_q;  // Second stage, safe to decode.
	logic [W-1:0] neg_s2_q;  // Second stage, safe to decode.

	// Two flip-flop synchroniser; only the second stage is decoded.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			pos_s1_q <= '0;
			neg_s1_q <= '0;
			pos_s2_q <= '0;
			neg_s2_q <= '0;
		end else begin
			pos_s1_q <= pos_i;
			neg_s1_q <= neg_i;
			pos_s2_q <= pos_s1_q;
			neg_s2_q <= neg_s1_q;
		end
	end

	// Analog pairs use the differential zero crossing; digital uses the top half.
	always_comb begin
		if (analog_i) begin
			bit_o = (pos_s2_q > neg_s2_q);
		end else begin
			bit_o = pos_s2_q[W-1];
		end
	end
endmodule
`default_nettype wire

/* logic/hall_trapezoid_commutator.sv */
// Purpose: Sensored six-step commutation with strap or register setup.
// Assumes: APB slave with zero wait states; straps arrive as level classes.
// Notes: Gate outputs are registered, three clocks behind the Hall pins.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Six-step table indexed by Hall code drives switches
// - PWM input sets modulated phase frequency, duty
// - Seven schemes; async, sync, rectified, unassigned
// - Seven strap levels select schemes one to seven
// - Analog compares pair; digital uses positive only
// - Scheme alone selects analog or digital sensing
// - Asynchronous schemes keep modulated low side off
// - Forward asynchronous code to phase mapping table
// - Code 000 all off; 111 aligns phase A
// - Reverse direction uses complemented step codes
// - Synchronous low side gets complemented PWM
// - Brake: highs off, lows on, overrides all
// - Straps sampled once after reset, then held
// - Straps set lead angle, scheme, slew rate
// - Serial output enabled only while select low
// - Serial output open-drain or push-pull selectable
// - Lead code selects zero to thirty degrees
module hall_trapezoid_commutator #(
	parameter int HALL_W   = 8,
	parameter int PERIOD_W = 20
) (
	// Clock and reset.
	input  wire logic                       sys_clk_i,
	input  wire logic                       srst_i,
	// APB slave.
	input  wire logic [hall_pkg::ADDR_W-1:0] paddr_i,
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [31:0]                pwdata_i,
	output logic [31:0]                     prdata_o,
	output logic                            pready_o,
	output logic                            pslverr_o,
	// Hall sensor pairs.
	input  wire logic [HALL_W-1:0]          hall_pos_in_a_i,
	input  wire logic [HALL_W-1:0]          hall_pos_in_b_i,
	input  wire logic [HALL_W-1:0]          hall_pos_in_c_i,
	input  wire logic [HALL_W-1:0]          hall_neg_in_a_i,
	input  wire logic [HALL_W-1:0]          hall_neg_in_b_i,
	input  wire logic [HALL_W-1:0]          hall_neg_in_c_i,
	// Host control pins.
	input  wire logic                       pwm_i,
	input  wire logic                       dir_i,
	input  wire logic                       brake_i,
	// Strap level classes, zero is tied to ground.
	input  wire logic [2:0]                 scheme_strap_lvl_i,
	input  wire logic [1:0]                 slew_strap_lvl_i,
	input  wire logic [2:0]                 lead_strap_lvl_i,
	// Serial data output pin.
	input  wire logic                       ser_cs_n_i,
	input  wire logic                       ser_data_i,
	output logic                            sdo_o,
	output logic                            sdo_oe_o,
	// Bridge and configuration outputs.
	output hall_pkg::bridge_s               bridge_o,
	output logic [1:0]                      slew_code_o,
	output logic                            active_sync_rectify_o,
	output logic                            active_async_rectify_o
);
	logic [1:0]        ctl_s1_q;        // First stage of {brake, dir}.
	logic [1:0]        ctl_s2_q;        // Synchronised {brake, dir}.
	logic              brake_s;         // Synchronised brake.
	logic              dir_s;           // Synchronised direction.
	logic              strap_taken_q;   // Straps already captured.
	logic [2:0]        strap_scheme_q;  // Captured scheme level.
	logic [1:0]        strap_slew_q;    // Captured slew level.
	logic [2:0]        strap_lead_q;    // Captured lead level.
	logic [31:0]       ctrl_q;          // Control register.
	logic [31:0]       prdata_q;        // Read data held for the access phase.
	hall_pkg::scheme_e scheme;          // Scheme in force.
	logic              is_analog;       // Differential sensing.
	logic              is_sync;         // Synchronous modulation.
	wire logic [2:0]   code;            // Raw Hall code {A,B,C}, one bit per channel.
	logic [2:0]        fwd_code;        // Code in forward terms.
	logic              step_hit;        // Code names one of the six steps.
	logic [2:0]        step_idx;        // Step number for the code.
	logic [2:0]        prev_step_q;     // Step seen last cycle.
	logic [PERIOD_W-1:0] elapsed_q;     // Cycles spent in this step.
	logic [PERIOD_W-1:0] period_q;      // Length of the last whole step.
	logic [2:0]        lead_code;       // Lead code in force.
	logic [PERIOD_W+4:0] lead_prod;     // Period times lead degrees.
	logic [PERIOD_W-1:0] lead_thr;      // Cycles before an early step.
	logic              use_next;        // Commutate to the next step now.
	logic [2:0]        drive_idx;       // Step actually driven.
	logic [2:0]        hi_mask;         // Modulated phases.
	logic [2:0]        lo_mask;         // Low sides held on.
	hall_pkg::bridge_s bridge_d;        // Next gate pattern.
	hall_pkg::bridge_s bridge_q;        // Registered gate pattern.
	logic [HALL_W-1:0] pos_arr [3];     // Positive inputs, A first.
	logic [HALL_W-1:0] neg_arr [3];     // Negative inputs, A first.
	logic              wr_en;           // APB write at the access edge.
	logic              mapped;          // Address is a register.

	assign brake_s = ctl_s2_q[1];
	assign dir_s   = ctl_s2_q[0];

	// Synchronise the direction and brake pins.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctl_s1_q <= '0;
			ctl_s2_q <= '0;
		end else begin
			ctl_s1_q <= {brake_i, dir_i};
			ctl_s2_q <= ctl_s1_q;
		end
	end

	// Capture the straps once, in the first cycle after reset is released.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			strap_taken_q  <= 1'b0;
			strap_scheme_q <= 3'(hall_pkg::SCHEME_UNASSIGNED);
			strap_slew_q   <= '0;
			strap_lead_q   <= '0;
		end else if (!strap_taken_q) begin
			strap_taken_q  <= 1'b1;
			strap_scheme_q <= scheme_strap_lvl_i;
			strap_slew_q   <= slew_strap_lvl_i;
			strap_lead_q   <= lead_strap_lvl_i;
		end
	end

	// APB decode; the slave always answers in the first access cycle.
	assign mapped    = (paddr_i == hall_pkg::ADDR_CTRL) || (paddr_i == hall_pkg::ADDR_STATUS);
	assign wr_en     = psel_i && penable_i && pwrite_i && (paddr_i == hall_pkg::ADDR_CTRL);
	assign pready_o  = psel_i && penable_i;
	assign pslverr_o = psel_i && penable_i && !mapped;
	assign prdata_o  = prdata_q;

	// Control register write.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			ctrl_q <= hall_pkg::CTRL_RESET;
		end else if (wr_en) begin
			ctrl_q <= pwdata_i;
		end
	end

	// Read data is loaded in the setup cycle so it stands for the access phase.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prdata_q <= '0;
		end else if (psel_i && !penable_i) begin
			prdata_q <= '0;
			if (paddr_i == hall_pkg::ADDR_CTRL) begin
				prdata_q <= ctrl_q;
			end else if (paddr_i == hall_pkg::ADDR_STATUS) begin
				prdata_q[hall_pkg::ST_HALL_LSB +: 3]   <= code;
				prdata_q[hall_pkg::ST_SCHEME_LSB +: 3] <= 3'(scheme);
				prdata_q[hall_pkg::ST_STEP_LSB +: 3]   <= drive_idx;
				prdata_q[hall_pkg::ST_BRAKE_BIT]       <= brake_s;
				prdata_q[hall_pkg::ST_DIR_BIT]         <= dir_s;
				prdata_q[hall_pkg::ST_STRAP_LSB +: 3]  <= strap_scheme_q;
			end
		end
	end

	// Scheme comes from the register when selected, else from the strap.
	always_comb begin
		if (ctrl_q[hall_pkg::CTRL_SRC_BIT]) begin
			scheme = hall_pkg::scheme_e'(ctrl_q[hall_pkg::CTRL_SCHEME_LSB +: 3]);
		end else begin
			scheme = hall_pkg::scheme_e'(strap_scheme_q);
		end
		if (scheme > hall_pkg::SCHEME_UNASSIGNED) begin
			scheme = hall_pkg::SCHEME_UNASSIGNED;
		end
	end

	// Sensing and modulation flavour follow from the scheme only.
	assign is_analog = (scheme == hall_pkg::SCHEME_ASYNC_ANALOG) ||
		(scheme == hall_pkg::SCHEME_SYNC_ANALOG) ||
		(scheme == hall_pkg::SCHEME_RECT_ANALOG);
	assign is_sync = (scheme != hall_pkg::SCHEME_ASYNC_ANALOG) &&
		(scheme != hall_pkg::SCHEME_ASYNC_DIGITAL);
	assign active_sync_rectify_o  = (scheme == hall_pkg::SCHEME_RECT_ANALOG) ||
		(scheme == hall_pkg::SCHEME_RECT_DIGITAL);
	assign active_async_rectify_o = active_sync_rectify_o;

	// Three identical Hall channels, A drives the top code bit.
	assign pos_arr = '{hall_pos_in_a_i, hall_pos_in_b_i, hall_pos_in_c_i};
	assign neg_arr = '{hall_neg_in_a_i, hall_neg_in_b_i, hall_neg_in_c_i};
	for (genvar g = 0; g < 3; g++) begin : gen_hall
		hall_channel #(.W(HALL_W)) u_chan (
			.sys_clk_i (sys_clk_i),
			.srst_i    (srst_i),
			.pos_i     (pos_arr[g]),
			.neg_i     (neg_arr[g]),
			.analog_i  (is_analog),
			.bit_o     (code[2-g])
		);
	end

	// Reverse direction complements the step codes; stop and align stay put.
	always_comb begin
		fwd_code = code;
		if (dir_s && code != hall_pkg::CODE_STOP && code != hall_pkg::CODE_ALIGN) begin
			fwd_code = ~code;
		end
		step_hit = 1'b0;
		step_idx = hall_pkg::STEP_FIRST;
		for (int i = 0; i < hall_pkg::STEPS; i++) begin
			if (fwd_code == hall_pkg::STEP_CODE[i]) begin
				step_hit = 1'b1;
				step_idx = 3'(i);
			end
		end
	end

	// Measure the length of each step so the lead can be timed.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prev_step_q <= hall_pkg::STEP_FIRST;
			elapsed_q   <= '0;
			period_q    <= '0;
		end else begin
			prev_step_q <= step_idx;
			if (step_hit && step_idx != prev_step_q) begin
				period_q  <= elapsed_q;
				elapsed_q <= '0;
			end else if (!(&elapsed_q)) begin
				elapsed_q <= elapsed_q + 1'b1;
			end
		end
	end

	// Lead code and slew come from the register when selected.
	always_comb begin
		if (ctrl_q[hall_pkg::CTRL_SRC_BIT]) begin
			lead_code   = ctrl_q[hall_pkg::CTRL_LEAD_LSB +: 3];
			slew_code_o = ctrl_q[hall_pkg::CTRL_SLEW_LSB +: 2];
		end else begin
			lead_code = hall_pkg::LEAD_STRAP_CODE[hall_pkg::STRAP_LVL_MAX];
			if (strap_lead_q <= hall_pkg::STRAP_LVL_MAX) begin
				lead_code = hall_pkg::LEAD_STRAP_CODE[strap_lead_q];
			end
			slew_code_o = strap_slew_q;
		end
	end

	// Step early once the remaining part of the step equals the lead angle.
	always_comb begin
		lead_prod = period_q * hall_pkg::LEAD_DEG[lead_code];
		lead_thr  = period_q - PERIOD_W'(lead_prod / hall_pkg::DEG_PER_STEP);
		use_next  = step_hit && (period_q != '0) && (&elapsed_q == 1'b0) &&
			(hall_pkg::LEAD_DEG[lead_code] != hall_pkg::DEG_ZERO) &&
			(step_idx == prev_step_q) && (elapsed_q >= lead_thr);
		drive_idx = step_idx;
		if (use_next) begin
			drive_idx = (step_idx == hall_pkg::STEP_LAST) ? hall_pkg::STEP_FIRST :
				step_idx + hall_pkg::STEP_INC;
		end
	end

	// Gate pattern: brake first, then stop, unassigned, align, table steps.
	always_comb begin
		hi_mask = '0;
		lo_mask = '0;
		if (code == hall_pkg::CODE_ALIGN) begin
			hi_mask = hall_pkg::ALIGN_HI;
			lo_mask = hall_pkg::ALIGN_LO;
		end else if (step_hit) begin
			hi_mask = hall_pkg::STEP_HI[drive_idx];
			lo_mask = hall_pkg::STEP_LO[drive_idx];
		end
		if (scheme == hall_pkg::SCHEME_UNASSIGNED) begin
			hi_mask = '0;
			lo_mask = '0;
		end
		bridge_d.hs = hi_mask & {3{pwm_i}};
		bridge_d.ls = lo_mask;
		if (is_sync) begin
			bridge_d.ls = lo_mask | (hi_mask & ~{3{pwm_i}});
		end
		if (brake_s) begin
			bridge_d.hs = '0;
			bridge_d.ls = '1;
		end
	end

	// Registered gate outputs keep decode glitches off the bridge.
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			bridge_q <= '0;
		end else begin
			bridge_q <= bridge_d;
		end
	end
	assign bridge_o = bridge_q;

	// Serial output drives only while selected, in the chosen driver style.
	always_comb begin
		sdo_o    = ser_data_i;
		sdo_oe_o = !ser_cs_n_i;
		if (ctrl_q[hall_pkg::CTRL_SDO_OD_BIT]) begin
			sdo_o    = 1'b0;
			sdo_oe_o = !ser_cs_n_i && !ser_data_i;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	brake_drive_a: assert property (brake_s |=> bridge_o.hs == '0 && bridge_o.ls == '1)
		else $error("Brake did not force lows on and highs off");
	stop_code_a: assert property (!brake_s && code == hall_pkg::CODE_STOP |=> bridge_o == '0)
		else $error("Stop code left a switch on");
	align_low_a: assert property (!brake_s && code == hall_pkg::CODE_ALIGN && scheme != hall_pkg::SCHEME_UNASSIGNED |=> bridge_o.ls[2:1] == 2'b11 && bridge_o.hs[2:1] == 2'b00)
		else $error("Align code drove the wrong switches");
	pwm_high_a: assert property (!brake_s |=> bridge_o.hs == ($past(hi_mask) & {3{$past(pwm_i)}}))
		else $error("High side does not follow the PWM input");
	async_ls_a: assert property (!brake_s && !is_sync |=> (bridge_o.hs & bridge_o.ls) == '0 && (bridge_o.ls & $past(hi_mask)) == '0)
		else $error("Asynchronous scheme turned on a modulated low side");
	sync_comp_a: assert property (!brake_s && is_sync |=> (bridge_o.ls & $past(hi_mask)) == ($past(hi_mask) & ~{3{$past(pwm_i)}}))
		else $error("Synchronous low side is not the PWM complement");
	unassigned_off_a: assert property (!brake_s && scheme == hall_pkg::SCHEME_UNASSIGNED |=> bridge_o == '0)
		else $error("Unassigned scheme drove the bridge");
	strap_hold_a: assert property (strap_taken_q |=> strap_taken_q && $stable(strap_scheme_q) && $stable(strap_lead_q))
		else $error("Strap value changed after capture");
	sdo_select_a: assert property (ser_cs_n_i |-> !sdo_oe_o)
		else $error("Serial output driven while not selected");
	sdo_drain_a: assert property (ctrl_q[hall_pkg::CTRL_SDO_OD_BIT] |-> !sdo_o)
		else $error("Open-drain serial output drove high");
	hall_delay_a: assert property (!brake_s && !dir_s && !use_next &&
		code == hall_pkg::STEP_CODE[0] && scheme != hall_pkg::SCHEME_UNASSIGNED |=>
		bridge_o.ls == (hall_pkg::STEP_LO[0] | (hall_pkg::STEP_HI[0] &
		{3{$past(is_sync) && !$past(pwm_i)}})))
		else $error("Step one low side not driven");

	brake_seen_c: cover property (!brake_s ##1 brake_s);
	align_seen_c: cover property (code == hall_pkg::CODE_ALIGN && !brake_s);
	lead_used_c: cover property (use_next);
	reverse_step_c: cover property (dir_s && step_hit);
endmodule
`default_nettype wire

/* bench/hall_motor_model.sv */
// Purpose: Behavioural Hall sensor set of a three-phase motor.
// Assumes: The bench chooses the position code {A,B,C} and the sensor kind.
// Notes: Unused negative lines float, so they show a pattern that flips every cycle.
`timescale 1ns/1ps
`default_nettype none
module hall_motor_model #(
	parameter int W = 8
) (
	// Clock.
	input  wire logic           clk_i,
	// Position and sensor kind.
	input  wire logic [2:0]     code_i,
	input  wire logic           analog_i,
	// Sensor lines, phase A in the lowest slice.
	output logic      [3*W-1:0] pos_o,
	output logic      [3*W-1:0] neg_o
);
	// Floating line level, never a steady value.
	logic [W-1:0] float_q = {(W/2){2'b01}};

	// The float pattern flips on every clock.
	always_ff @(posedge clk_i) begin
		float_q <= ~float_q;
	end

	// An analog one has pos above neg but a low top bit, so a wrong sensing kind shows.
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (analog_i) begin
				pos_o[i*W +: W] = code_i[2-i] ? W'(8'h60) : W'(8'ha0);
				neg_o[i*W +: W] = code_i[2-i] ? W'(8'h20) : W'(8'he0);
			end else begin
				pos_o[i*W +: W] = code_i[2-i] ? W'(8'hc0) : W'(8'h30);
				neg_o[i*W +: W] = float_q;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: Self-checking bench for the Hall commutation block.
// Assumes: Zero-wait APB slave; gates follow Hall pins by three clocks.
// Notes: Table steps are entered from the stop code so no rotation is seen; the lead test rotates.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                clk = 1'b0;
	logic                srst = 1'b1;
	logic [7:0]          paddr = 8'h00;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [31:0]         pwdata = 32'h0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic [23:0]         pos;
	logic [23:0]         neg;
	logic [2:0]          code = 3'h0;
	logic                analog = 1'b1;
	logic                pwm = 1'b0;
	logic                dir = 1'b0;
	logic                brake = 1'b0;
	logic [2:0]          sch_lvl = 3'h0;
	logic                cs_n = 1'b1;
	logic                sdat = 1'b0;
	logic                sdo;
	logic                sdo_oe;
	hall_pkg::bridge_s   bridge;
	logic [1:0]          slew_code;
	logic                active_sync_rectify;
	logic                active_async_rectify;
	int                  err_count = 0;
	int                  total_checks = 0;
	int                  cyc = 0;

	// Clock of 4 ns period.
	initial begin
		forever #2 clk = ~clk;
	end

	hall_trapezoid_commutator hall_trapezoid_commutator_i (
		.sys_clk_i(clk), .srst_i(srst), .paddr_i(paddr), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .hall_pos_in_a_i(pos[7:0]),
		.hall_pos_in_b_i(pos[15:8]), .hall_pos_in_c_i(pos[23:16]),
		.hall_neg_in_a_i(neg[7:0]), .hall_neg_in_b_i(neg[15:8]),
		.hall_neg_in_c_i(neg[23:16]), .pwm_i(pwm), .dir_i(dir), .brake_i(brake),
		.scheme_strap_lvl_i(sch_lvl), .slew_strap_lvl_i(2'h2), .lead_strap_lvl_i(3'h0),
		.ser_cs_n_i(cs_n), .ser_data_i(sdat), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
		.bridge_o(bridge), .slew_code_o(slew_code), .active_sync_rectify_o(active_sync_rectify),
		.active_async_rectify_o(active_async_rectify));

	hall_motor_model hall_motor_model_i (.clk_i(clk), .code_i(code), .analog_i(analog),
		.pos_o(pos), .neg_o(neg));

	// Ends the run with the verdict.
	task report_and_stop();
		if (err_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch.
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Holds reset for three clocks.
	task do_reset();
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
	endtask

	// One APB transfer, held until pready is seen high.
	task apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Applies a Hall code and PWM level, then lets w clocks pass.
	task hall(input logic [2:0] c, input logic p, input int w);
		@(posedge clk);
		code <= c;
		pwm <= p;
		repeat (w) @(posedge clk);
	endtask

	// Expected gates {hs, ls} for a scheme index, Hall code, direction and PWM.
	function automatic logic [5:0] exp_br(int s, logic [2:0] c, logic d, logic p);
		logic [2:0] k;
		logic [2:0] hi;
		logic [2:0] lo;
		k = (d && c != 3'h0 && c != 3'h7) ? ~c : c;
		case (k)
			3'h6: {hi, lo} = 6'h14;
			3'h4: {hi, lo} = 6'h0c;
			3'h5: {hi, lo} = 6'h0a;
			3'h1: {hi, lo} = 6'h22;
			3'h3: {hi, lo} = 6'h21;
			3'h2: {hi, lo} = 6'h11;
			3'h7: {hi, lo} = 6'h0e;
			default: {hi, lo} = 6'h00;
		endcase
		if (s == 6) begin
			return 6'h00;
		end
		return {p ? hi : 3'h0, lo | ((s >= 2 && !p) ? hi : 3'h0)};
	endfunction

	// Each strap level, sampled at reset and then held.
	task t_straps();
		logic [31:0] rd;
		logic        e;
		for (int l = 0; l < 7; l++) begin
			sch_lvl <= 3'(l);
			do_reset();
			sch_lvl <= 3'(6 - l);
			apb(hall_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, e);
			chk({29'h0, rd[13:11]}, l);
			chk({29'h0, rd[5:3]}, l);
			chk({30'h0, active_sync_rectify, active_async_rectify}, (l == 4 || l == 5) ? 32'h3 : 32'h0);
			chk(slew_code, 2'h2);
		end
		apb(hall_pkg::ADDR_CTRL, 1'b0, 32'h0, rd, e);
		chk(rd, hall_pkg::CTRL_RESET);
	endtask

	// Full table in one scheme, both directions, both PWM levels.
	task t_table(input int s);
		logic [31:0] rd;
		logic        e;
		@(posedge clk);
		pwm <= 1'b0;
		apb(hall_pkg::ADDR_CTRL, 1'b1, 32'h181 | (32'(s) << 1), rd, e);
		analog <= (s % 2 == 0);
		for (int d = 0; d < 2; d++) begin
			dir <= d[0];
			for (int c = 0; c < 8; c++) begin
				hall(3'h0, 1'b0, 6);
				hall(3'(c), 1'b1, 4);
				chk(bridge, exp_br(s, 3'(c), d[0], 1'b1));
				hall(3'(c), 1'b0, 2);
				chk(bridge, exp_br(s, 3'(c), d[0], 1'b0));
			end
		end
		apb(hall_pkg::ADDR_STATUS, 1'b0, 32'h0, rd, e);
		chk({29'h0, rd[5:3]}, s);
		chk({30'h0, active_sync_rectify, active_async_rectify}, (s == 4 || s == 5) ? 32'h3 : 32'h0);
	endtask

	// Thirty degree lead: the next step is driven halfway through each step.
	task t_lead();
		logic [31:0] rd;
		logic        e;
		logic [2:0]  seq [6];
		seq = '{3'h6, 3'h4, 3'h5, 3'h1, 3'h3, 3'h2};
		pwm <= 1'b0;
		apb(hall_pkg::ADDR_CTRL, 1'b1, 32'h1f7, rd, e);
		analog <= 1'b0;
		dir <= 1'b0;
		for (int r = 0; r < 12; r++) begin
			hall(seq[r % 6], 1'b1, 12);
			if (r >= 6) begin
				chk(bridge, exp_br(3, seq[r % 6], 1'b0, 1'b1));
			end
			repeat (24) @(posedge clk);
			if (r >= 6) begin
				chk(bridge, exp_br(3, seq[(r + 1) % 6], 1'b0, 1'b1));
			end
			repeat (3) @(posedge clk);
		end
		pwm <= 1'b0;
	endtask

	// Brake, unmapped access, slew and serial pin drive.
	task t_misc();
		logic [31:0] rd;
		logic        e;
		brake <= 1'b1;
		hall(3'h5, 1'b1, 4);
		chk(bridge, 6'h07);
		brake <= 1'b0;
		pwm <= 1'b0;
		apb(8'h10, 1'b0, 32'h0, rd, e);
		chk({rd[30:0], e}, 32'h1);
		chk(slew_code, 2'h3);
		for (int od = 0; od < 2; od++) begin
			apb(hall_pkg::ADDR_CTRL, 1'b1, 32'h181 | (32'(od) << 9), rd, e);
			for (int k = 0; k < 4; k++) begin
				cs_n <= k[1];
				sdat <= k[0];
				repeat (2) @(posedge clk);
				chk({sdo, sdo_oe}, od ? {1'b0, !k[1] && !k[0]} : {k[0], !k[1]});
			end
		end
	endtask

	// Cuts a hang short.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			report_and_stop();
		end
	end

	// Main sequence.
	initial begin
		do_reset();
		t_straps();
		for (int s = 0; s < 7; s++) begin
			t_table(s);
		end
		t_lead();
		t_misc();
		report_and_stop();
	end
endmodule
`default_nettype wire
